// *** hdl/oled_init_pkg.sv ***
/*
  constants for the panel controller core: widths, command codes, reset values.
  assumes a single 200 mhz core clock; the serial link is sampled, not clocked.
*/
package oled_init_pkg;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ENTRY_W    = 9;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned BITCNT_W   = 3;
  localparam int unsigned COL_W      = 7;
  localparam int unsigned PAGE_W     = 3;
  localparam int unsigned LINE_W     = 6;
  localparam int unsigned ENTRY_DC   = 8;

  localparam logic [COL_W-1:0]  COL_LAST = 7'h7F;

  localparam logic [7:0] CMD_DISP_OFF   = 8'hAE;
  localparam logic [7:0] CMD_DISP_ON    = 8'hAF;
  localparam logic [7:0] CMD_RESUME_RAM = 8'hA4;
  localparam logic [7:0] CMD_ALL_ON     = 8'hA5;
  localparam logic [7:0] CMD_NORMAL     = 8'hA6;
  localparam logic [7:0] CMD_INVERSE    = 8'hA7;
  localparam logic [7:0] CMD_SEG_NORMAL = 8'hA0;
  localparam logic [7:0] CMD_SEG_REMAP  = 8'hA1;
  localparam logic [7:0] CMD_COM_NORMAL = 8'hC0;
  localparam logic [7:0] CMD_COM_REVERS = 8'hC8;
  localparam logic [7:0] CMD_CONTRAST   = 8'h81;
  localparam logic [7:0] CMD_MUX        = 8'hA8;
  localparam logic [7:0] CMD_OFFSET     = 8'hD3;
  localparam logic [7:0] CMD_CLKDIV     = 8'hD5;
  localparam logic [7:0] CMD_PRECHARGE  = 8'hD9;
  localparam logic [7:0] CMD_COMPINS    = 8'hDA;
  localparam logic [7:0] CMD_VCOMH      = 8'hDB;
  localparam logic [7:0] CMD_PUMP       = 8'h8D;
  localparam logic [7:0] CMD_ADDR_MODE  = 8'h20;

  // range-coded commands: upper bits select, lower bits carry the value
  localparam logic [1:0] PFX_START_LINE = 2'h1;
  localparam logic [3:0] PFX_COL_LOW    = 4'h0;
  localparam logic [4:0] PFX_COL_HIGH   = 5'h02;
  localparam logic [4:0] PFX_PAGE       = 5'h16;

  localparam logic [7:0]        CONTRAST_RST = 8'h7F;
  localparam logic [LINE_W-1:0] START_RST    = 6'h00;
  localparam logic [COL_W-1:0]  COL_RST      = 7'h00;
  localparam logic [PAGE_W-1:0] PAGE_RST     = 3'h0;
  localparam logic [LINE_W-1:0] MUX_RST      = 6'h3F;
  localparam logic [7:0]        ARG_RST      = 8'h00;

endpackage : oled_init_pkg

// *** hdl/byte_fifo.sv ***
/*
  small synchronous fifo with valid/ready on both sides and a flush.
  assumes one clock; width and depth are parameters, depth a power of two.
*/
`timescale 1ns/10ps
module byte_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             full;
  logic             empty;

  assign empty     = (wr_q == rd_q);
  assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

endmodule : byte_fifo

// *** hdl/serial_byte_rx.sv ***
/*
  4-wire serial receiver: assembles eight bits msb first into one entry.
  assumes all link inputs are already synchronised to clk; clear is a level.
*/
`timescale 1ns/10ps
module serial_byte_rx
  import oled_init_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               clear,
  input  wire logic               sclk_s,
  input  wire logic               cs_n_s,
  input  wire logic               dc_s,
  input  wire logic               sdata_s,
  output logic                    byte_valid,
  output logic      [ENTRY_W-1:0] byte_entry
);
  logic                sclk_prev_q;
  logic [BITCNT_W-1:0] cnt_q;
  logic [DATA_W-2:0]   shift_q;
  logic                rise;

  assign rise = sclk_s && !sclk_prev_q && !cs_n_s;

  always_ff @(posedge clk) begin
    if (clear) begin
      sclk_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  // partial bits are dropped on reset and whenever chip select is released
  always_ff @(posedge clk) begin
    if (clear || cs_n_s) begin
      cnt_q   <= '0;
      shift_q <= '0;
    end else if (rise) begin
      cnt_q   <= cnt_q + 1'b1;
      shift_q <= {shift_q[DATA_W-3:0], sdata_s};
    end
  end

  always_ff @(posedge clk) begin
    if (clear) begin
      byte_valid <= 1'b0;
      byte_entry <= '0;
    end else begin
      byte_valid <= rise && (cnt_q == '1);
      if (rise && (cnt_q == '1)) begin
        byte_entry <= {dc_s, shift_q, sdata_s};
      end
    end
  end

endmodule : serial_byte_rx

// *** hdl/oled_panel_reset_and_init.sv ***
/*
  panel controller core: reset defaults, serial command intake and decode.
  assumes link pins arrive asynchronously and the ram write port may stall.
*/
`timescale 1ns/10ps
// Contract
// - while panel reset is low the core returns to defaults with the display off.
// - after reset the core runs in 128 by 64 mode.
// - after reset segment and row mapping are normal, driver zero to address zero.
// - reset clears any partly shifted serial bits.
// - after reset the start line is ram address zero.
// - after reset the column counter is zero.
// - after reset the common outputs scan in the normal direction.
// - after reset the contrast is 7Fh.
// - after reset ram contents are shown normally, as command A4h selects.
// - command AEh turns the display off and AFh turns it on.
// - a command byte is eight bits msb first under chip select with select low.
// - a data byte uses the same framing with select high.
module oled_panel_reset_and_init
  import oled_init_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              panel_reset_n,
  input  wire logic              chip_select_n,
  input  wire logic              data_command_select,
  input  wire logic              shift_clk,
  input  wire logic              serial_data,
  output logic                   mem_wr_valid,
  input  wire logic              mem_wr_ready,
  output logic      [PAGE_W-1:0] mem_wr_page,
  output logic      [COL_W-1:0]  mem_wr_col,
  output logic      [7:0]        mem_wr_data,
  output logic                   display_on,
  output logic                   all_pixels_on,
  output logic                   inverse_video,
  output logic                   seg_remap,
  output logic                   com_reverse,
  output logic      [LINE_W-1:0] start_line,
  output logic      [LINE_W-1:0] mux_ratio,
  output logic      [7:0]        contrast,
  output logic      [7:0]        display_offset,
  output logic      [7:0]        clock_div,
  output logic      [7:0]        precharge,
  output logic      [7:0]        com_pins,
  output logic      [7:0]        vcomh_level,
  output logic      [7:0]        charge_pump,
  output logic      [7:0]        addr_mode,
  output logic                   rx_overrun,
  output logic                   in_reset
);

  typedef enum logic [1:0] {
    ST_CMD,
    ST_ARG,
    ST_WRITE
  } state_t;

  // pin synchronisers: stage one feeds stage two only
  logic [4:0] pin_meta_q;
  logic [4:0] pin_sync_q;
  logic       core_rst;

  always_ff @(posedge clk) begin
    if (srst) begin
      // both stages reset to the idle pin levels so no false edge follows reset
      pin_meta_q <= 5'h1E;
      pin_sync_q <= 5'h1E;
    end else begin
      pin_meta_q <= {panel_reset_n, chip_select_n, data_command_select, shift_clk, serial_data};
      pin_sync_q <= pin_meta_q;
    end
  end

  // external reset low or core reset holds every control register at default
  assign core_rst = srst || !pin_sync_q[4];
  assign in_reset = core_rst;

  // serial intake, held clear during reset so stray edges are not taken
  logic               rx_valid;
  logic [ENTRY_W-1:0] rx_entry;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic               fifo_out_ready;
  logic [ENTRY_W-1:0] fifo_out_data;

  serial_byte_rx u_rx (
    .clk        (clk),
    .clear      (core_rst),
    .sclk_s     (pin_sync_q[1]),
    .cs_n_s     (pin_sync_q[3]),
    .dc_s       (pin_sync_q[2]),
    .sdata_s    (pin_sync_q[0]),
    .byte_valid (rx_valid),
    .byte_entry (rx_entry)
  );

  // the link has no flow control, so a full fifo can only be reported
  byte_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .flush     (core_rst),
    .in_valid  (rx_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_entry),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge clk) begin
    if (core_rst) begin
      rx_overrun <= 1'b0;
    end else if (rx_valid && !fifo_in_ready) begin
      rx_overrun <= 1'b1;
    end
  end

  // decode
  state_t     state_q;
  state_t     state_d;
  logic [7:0] pend_cmd_q;
  logic [7:0] ebyte;
  logic       is_data;
  logic       take;
  logic       take_cmd;
  logic       take_arg;
  logic       wants_arg;

  assign ebyte          = fifo_out_data[DATA_W-1:0];
  assign is_data        = fifo_out_data[ENTRY_DC];
  assign fifo_out_ready = (state_q != ST_WRITE);
  assign take           = fifo_out_valid && fifo_out_ready;
  assign take_cmd       = take && !is_data && (state_q == ST_CMD);
  assign take_arg       = take && !is_data && (state_q == ST_ARG);
  assign mem_wr_valid   = (state_q == ST_WRITE);

  always_comb begin
    wants_arg = 1'b0;
    unique case (ebyte)
      CMD_CONTRAST, CMD_MUX, CMD_OFFSET, CMD_CLKDIV, CMD_PRECHARGE,
      CMD_COMPINS, CMD_VCOMH, CMD_PUMP, CMD_ADDR_MODE: wants_arg = 1'b1;
      default: wants_arg = 1'b0;
    endcase
  end

  // a data byte arriving while an argument is pending cancels that argument
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_CMD: begin
        if (take && is_data) begin
          state_d = ST_WRITE;
        end else if (take_cmd && wants_arg) begin
          state_d = ST_ARG;
        end
      end
      ST_ARG: begin
        if (take) begin
          state_d = is_data ? ST_WRITE : ST_CMD;
        end
      end
      ST_WRITE: begin
        if (mem_wr_ready) begin
          state_d = ST_CMD;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      state_q    <= ST_CMD;
      pend_cmd_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (take_cmd) begin
        pend_cmd_q <= ebyte;
      end
    end
  end

  // display on/off and the picture modes
  always_ff @(posedge clk) begin
    if (core_rst) begin
      display_on    <= 1'b0;
      all_pixels_on <= 1'b0;
      inverse_video <= 1'b0;
      seg_remap     <= 1'b0;
      com_reverse   <= 1'b0;
    end else if (take_cmd) begin
      unique case (ebyte)
        CMD_DISP_OFF:   display_on    <= 1'b0;
        CMD_DISP_ON:    display_on    <= 1'b1;
        CMD_RESUME_RAM: all_pixels_on <= 1'b0;
        CMD_ALL_ON:     all_pixels_on <= 1'b1;
        CMD_NORMAL:     inverse_video <= 1'b0;
        CMD_INVERSE:    inverse_video <= 1'b1;
        CMD_SEG_NORMAL: seg_remap     <= 1'b0;
        CMD_SEG_REMAP:  seg_remap     <= 1'b1;
        CMD_COM_NORMAL: com_reverse   <= 1'b0;
        CMD_COM_REVERS: com_reverse   <= 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      start_line <= START_RST;
    end else if (take_cmd && (ebyte[7:6] == PFX_START_LINE)) begin
      start_line <= ebyte[LINE_W-1:0];
    end
  end

  // two-byte commands take their argument from the next command byte
  always_ff @(posedge clk) begin
    if (core_rst) begin
      contrast       <= CONTRAST_RST;
      mux_ratio      <= MUX_RST;
      display_offset <= ARG_RST;
      clock_div      <= ARG_RST;
      precharge      <= ARG_RST;
      com_pins       <= ARG_RST;
      vcomh_level    <= ARG_RST;
      charge_pump    <= ARG_RST;
      addr_mode      <= ARG_RST;
    end else if (take_arg) begin
      unique case (pend_cmd_q)
        CMD_CONTRAST:  contrast       <= ebyte;
        CMD_MUX:       mux_ratio      <= ebyte[LINE_W-1:0];
        CMD_OFFSET:    display_offset <= ebyte;
        CMD_CLKDIV:    clock_div      <= ebyte;
        CMD_PRECHARGE: precharge      <= ebyte;
        CMD_COMPINS:   com_pins       <= ebyte;
        CMD_VCOMH:     vcomh_level    <= ebyte;
        CMD_PUMP:      charge_pump    <= ebyte;
        CMD_ADDR_MODE: addr_mode      <= ebyte;
        default: ;
      endcase
    end
  end

  // column and page pointers; column wraps after the last column
  always_ff @(posedge clk) begin
    if (core_rst) begin
      mem_wr_col  <= COL_RST;
      mem_wr_page <= PAGE_RST;
    end else if (take_cmd && (ebyte[7:4] == PFX_COL_LOW)) begin
      mem_wr_col <= {mem_wr_col[COL_W-1:4], ebyte[3:0]};
    end else if (take_cmd && (ebyte[7:3] == PFX_COL_HIGH)) begin
      mem_wr_col <= {ebyte[2:0], mem_wr_col[3:0]};
    end else if (take_cmd && (ebyte[7:3] == PFX_PAGE)) begin
      mem_wr_page <= ebyte[PAGE_W-1:0];
    end else if (mem_wr_valid && mem_wr_ready) begin
      mem_wr_col <= (mem_wr_col == COL_LAST) ? COL_RST : mem_wr_col + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      mem_wr_data <= 8'h00;
    end else if (take && is_data) begin
      mem_wr_data <= ebyte;
    end
  end

endmodule : oled_panel_reset_and_init

// *** dv/oled_init_assertions.sv ***
/*
  concurrent checks on the panel controller core: reset defaults and ram write handshake.
  assumes it is bound to the core and sees only its ports, one clock, srst synchronous.
*/
`timescale 1ns/10ps
module oled_init_assertions
  import oled_init_pkg::*;
(
  input wire logic              clk,
  input wire logic              srst,
  input wire logic              in_reset,
  input wire logic              mem_wr_valid,
  input wire logic              mem_wr_ready,
  input wire logic [PAGE_W-1:0] mem_wr_page,
  input wire logic [COL_W-1:0]  mem_wr_col,
  input wire logic [7:0]        mem_wr_data,
  input wire logic              display_on,
  input wire logic              all_pixels_on,
  input wire logic              seg_remap,
  input wire logic              com_reverse,
  input wire logic [LINE_W-1:0] start_line,
  input wire logic [LINE_W-1:0] mux_ratio,
  input wire logic [7:0]        contrast
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // three cycles: in_reset follows the synced pin directly, but registers take their defaults one clock after it rises
  sequence s_held_reset;
    in_reset ##1 in_reset ##1 in_reset;
  endsequence
  sequence s_stalled;
    !in_reset && mem_wr_valid && !mem_wr_ready;
  endsequence
  sequence s_taken;
    !in_reset && mem_wr_valid && mem_wr_ready;
  endsequence
  a_reset_display_off: assert property (s_held_reset |-> !display_on)
    else $error("display on while held in reset");
  a_reset_full_mux: assert property (s_held_reset |-> mux_ratio == 6'h3F)
    else $error("mux ratio not 64 rows in reset");
  a_reset_seg_map: assert property (s_held_reset |-> !seg_remap)
    else $error("segment remap set in reset");
  a_reset_start_line: assert property (s_held_reset |-> start_line == 6'h00)
    else $error("start line not zero in reset");
  a_reset_column_zero: assert property (s_held_reset |-> mem_wr_col == 7'h00 && mem_wr_page == 3'h0)
    else $error("column not zero in reset");
  a_reset_com_scan: assert property (s_held_reset |-> !com_reverse)
    else $error("common scan reversed in reset");
  a_reset_contrast_value: assert property (s_held_reset |-> contrast == 8'h7F)
    else $error("contrast not default in reset");
  a_reset_show_ram: assert property (s_held_reset |-> !all_pixels_on)
    else $error("all pixels forced in reset");
  a_reset_no_write: assert property (s_held_reset |-> !mem_wr_valid)
    else $error("ram write during reset");
  a_write_held_stable: assert property (s_stalled |=> in_reset || (mem_wr_valid && $stable(mem_wr_data) && $stable(mem_wr_col)))
    else $error("stalled ram write changed");
  a_write_column_step: assert property (s_taken |=> in_reset || (!mem_wr_valid && mem_wr_col == $past(mem_wr_col) + 7'h01))
    else $error("column did not step after write");
endmodule : oled_init_assertions

bind oled_panel_reset_and_init oled_init_assertions chk (.*);

// *** dv/serial_host.sv ***
/*
  behavioural host on the 4-wire serial link: frames bytes msb first under chip select.
  assumes the caller waits for the task; link clock 125 ns, idle high between frames.
*/
`timescale 1ns/10ps
module serial_host (
  output logic cs_n,
  output logic dc,
  output logic sclk,
  output logic sdata
);
  initial begin
    cs_n = 1'b1;
    dc = 1'b0;
    sclk = 1'b1;
    sdata = 1'b0;
  end
  // n below 8 leaves chip select low, to strand a partial byte
  task send(input logic d, input logic [7:0] b, input int n);
    cs_n = 1'b0;
    dc = d;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      sdata = b[7-i];
      #62.5;
      sclk = 1'b1;
      #62.5;
    end
    if (n == 8) begin
      cs_n = 1'b1;
      // released line shows no stale bit
      sdata = ~sdata;
      dc = ~dc;
      #125;
    end
  endtask : send
endmodule : serial_host

// *** dv/oled_panel_reset_and_init_test.sv ***
/*
  self-checking bench for the panel controller core: defaults, commands, ram writes, overrun.
  assumes the serial_host model on the link and a random-stalling ram write port.
*/
`timescale 1ns/10ps
module oled_panel_reset_and_init_test;
  import oled_init_pkg::*;
  logic clk = 1'b0, srst = 1'b1, panel_reset_n = 1'b1, mem_wr_ready = 1'b0, stall = 1'b0;
  wire logic chip_select_n, data_command_select, shift_clk, serial_data;
  logic mem_wr_valid, display_on, all_pixels_on, inverse_video, seg_remap, com_reverse, rx_overrun, in_reset;
  logic [PAGE_W-1:0] mem_wr_page;
  logic [COL_W-1:0]  mem_wr_col, exp_col;
  logic [LINE_W-1:0] start_line, mux_ratio;
  logic [7:0] mem_wr_data, contrast, display_offset, clock_div, precharge, com_pins;
  logic [7:0] vcomh_level, charge_pump, addr_mode, r, exp_q[$];
  logic [7:0] ops[8] = '{8'hA5, 8'hA4, 8'hA7, 8'hA6, 8'hA1, 8'hA0, 8'hC8, 8'hC0};
  logic [3:0] sel;
  localparam logic [63:0] ARG_OPS = {CMD_MUX, CMD_OFFSET, CMD_CLKDIV, CMD_PRECHARGE,
                                     CMD_COMPINS, CMD_VCOMH, CMD_PUMP, CMD_ADDR_MODE};
  wire logic [63:0] args_seen = {{2'b00, mux_ratio}, display_offset, clock_div, precharge,
                                 com_pins, vcomh_level, charge_pump, addr_mode};
  integer seed = 32'h7bcd;
  int n_mismatch = 0, check_count = 0, n_wr = 0, w0;

  always #2.5 clk = ~clk;
  serial_host host (.cs_n(chip_select_n), .dc(data_command_select), .sclk(shift_clk), .sdata(serial_data));
  oled_panel_reset_and_init dut (.*);

  always @(posedge clk) mem_wr_ready <= !stall && ($random(seed) % 4 != 0);

  function automatic logic [COL_W-1:0] next_col(input logic [COL_W-1:0] c);
    return c + 7'h01;
  endfunction : next_col

  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  always @(posedge clk) if (mem_wr_valid && mem_wr_ready) begin
    n_wr++;
    if (exp_q.size() > 0) begin
      chk("mem_wr_data", exp_q.pop_front(), mem_wr_data);
      chk("mem_wr_col", {1'b0, exp_col}, {1'b0, mem_wr_col});
      exp_col = next_col(exp_col);
    end
  end

  task cmd(input logic [7:0] b);
    host.send(1'b0, b, 8);
    repeat (12) @(posedge clk);
  endtask : cmd

  task pulse_reset(input logic by_srst);
    @(posedge clk);
    if (by_srst) srst <= 1'b1;
    else panel_reset_n <= 1'b0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    panel_reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    exp_col = 7'h00;
  endtask : pulse_reset

  task defaults;
    chk("display_on", 8'h00, {7'h00, display_on});
    chk("mux_ratio", 8'h3F, {2'b00, mux_ratio});
    chk("seg_remap", 8'h00, {7'h00, seg_remap});
    chk("start_line", 8'h00, {2'b00, start_line});
    chk("mem_wr_col", 8'h00, {1'b0, mem_wr_col});
    chk("com_reverse", 8'h00, {7'h00, com_reverse});
    chk("contrast", 8'h7F, contrast);
    chk("all_pixels_on", 8'h00, {7'h00, all_pixels_on});
  endtask : defaults

  task test_done;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  initial begin
    // about twice the expected run, well under the cycle budget
    #400_000;
    n_mismatch++;
    test_done();
  end

  initial begin
    exp_col = 7'h00;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    defaults();
    cmd(CMD_DISP_OFF);
    chk("display_on", 8'h00, {7'h00, display_on});
    r = $random(seed);
    cmd(CMD_CONTRAST);
    cmd(r);
    chk("contrast", r, contrast);
    for (int i = 0; i < 8; i++) begin
      cmd(ops[i]);
      sel = {all_pixels_on, inverse_video, seg_remap, com_reverse};
      chk("mode bit", {7'h00, !i[0]}, {7'h00, sel[3-i/2]});
    end
    r = $random(seed);
    cmd({2'b01, r[5:0]});
    chk("start_line", {2'b00, r[5:0]}, {2'b00, start_line});
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      cmd(ARG_OPS[63-8*i -: 8]);
      cmd(r);
      chk("argument", (i == 0) ? {2'b00, r[5:0]} : r, args_seen[63-8*i -: 8]);
    end
    cmd(8'hB5);
    chk("mem_wr_page", 8'h05, {5'h00, mem_wr_page});
    cmd(8'h03);
    cmd(8'h12);
    chk("mem_wr_col", 8'h23, {1'b0, mem_wr_col});
    exp_col = 7'h23;
    // random ram writes from column 23h: includes column wrap past the last column
    for (int i = 0; i < 140; i++) begin
      r = $random(seed);
      exp_q.push_back(r);
      host.send(1'b1, r, 8);
    end
    for (int k = 0; k < 400 && exp_q.size() > 0; k++) @(posedge clk);
    chk("writes left", 8'h00, exp_q.size());
    cmd(CMD_DISP_ON);
    chk("display_on", 8'h01, {7'h00, display_on});
    pulse_reset(1'b0);
    defaults();
    // a byte sent with the pin low must leave no trace
    @(posedge clk);
    panel_reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    cmd(CMD_DISP_ON);
    panel_reset_n <= 1'b1;
    repeat (12) @(posedge clk);
    chk("display_on", 8'h00, {7'h00, display_on});
    cmd(CMD_DISP_ON);
    chk("display_on", 8'h01, {7'h00, display_on});
    // stranded bits before a reset must not prefix the next byte
    host.send(1'b0, 8'h00, 5);
    pulse_reset(1'b1);
    cmd(CMD_DISP_ON);
    chk("display_on", 8'h01, {7'h00, display_on});
    stall <= 1'b1;
    w0 = n_wr;
    for (int i = 0; i < 14; i++) host.send(1'b1, 8'h5A, 8);
    repeat (12) @(posedge clk);
    chk("rx_overrun", 8'h01, {7'h00, rx_overrun});
    stall <= 1'b0;
    repeat (100) @(posedge clk);
    chk("drained", 8'h01, {7'h00, (n_wr - w0) >= FIFO_DEPTH});
    cmd(CMD_DISP_OFF);
    chk("display_on", 8'h00, {7'h00, display_on});
    test_done();
  end
endmodule : oled_panel_reset_and_init_test
